/* File: fcc_feac_ctrl.sv */
// FEAC codeword transmitter, receiver and receive code FIFO with Avalon-MM registers
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`include "fcc_params.svh"

module fcc_feac_ctrl
  import fcc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic [`FCC_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic                   tx_bit_en_i,
  output logic                        tx_bit_o,
  input  wire logic                   rx_bit_en_i,
  input  wire logic                   rx_bit_i,
  output logic                        rx_code_detected_o,
  output logic                        rx_idle_o
);

  localparam int PW = $clog2(FIFO_DEPTH);

  // Bus slave
  logic                   wait_r;
  logic [31:0]            rdata_r;
  logic                   wr_acc;
  logic                   rd_acc;
  // Transmit
  fcc_mode_t              mode_r;
  fcc_tx_state_t          tx_st_r;
  logic [5:0]             tx_code_first_r;
  logic [5:0]             tx_code_second_r;
  logic [3:0]             bit_cnt_r;
  logic [3:0]             rep_cnt_r;
  logic                   tx_bit_r;
  logic [5:0]             tx_code;
  // Receive
  logic [15:0]            sr_r;
  logic [15:0]            sr_nxt;
  logic                   match;
  logic [5:0]             rx_code;
  logic [5:0]             last_code_r;
  logic [1:0]             run_r;
  logic [4:0]             since_r;
  logic [4:0]             ones_r;
  logic                   diff_r;
  logic                   push;
  logic                   differ;
  logic                   det_r;
  logic                   idle_r;
  logic                   ovf_r;
  logic [5:0]             cur_code_r;
  fcc_rx_status_t         rx_r;
  // FIFO
  logic [5:0]             mem_r [FIFO_DEPTH];
  logic [PW-1:0]          wr_ptr_r;
  logic [PW-1:0]          rd_ptr_r;
  logic [PW:0]            lvl_r;
  logic                   full;
  logic                   empty;
  logic                   pop;

  // Codeword bit at a given position, code held with MSB at bit 0
  function automatic logic cw_bit(input logic [5:0] code, input logic [3:0] idx);
    logic b;
    b = 1'b1;
    if (idx == 4'h0 || idx == 4'h7) begin
      b = 1'b0;
    end else if (idx <= 4'h6) begin
      b = code[3'(idx - 4'h1)];
    end
    return b;
  endfunction : cw_bit

  // Avalon-MM slave
  assign wr_acc = avs_write_i & ~wait_r & avs_byteenable_i[0];
  assign rd_acc = avs_read_i & ~wait_r;

  // One wait cycle per access, then one accepting cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= `FCC_RST_DATA;
    end else if (avs_read_i && wait_r) begin
      rdata_r <= `FCC_RST_DATA;
      unique case (avs_address_i)
        `FCC_OFS_CTRL:      rdata_r[1:0] <= mode_r;
        `FCC_OFS_TX_FIRST:  rdata_r[5:0] <= tx_code_first_r;
        `FCC_OFS_TX_SECOND: rdata_r[5:0] <= tx_code_second_r;
        `FCC_OFS_STATUS: begin
          rdata_r[`FCC_ST_DET]    <= rx_r.det;
          rdata_r[`FCC_ST_IDLE]   <= rx_r.idle;
          rdata_r[`FCC_ST_EMPTY]  <= empty;
          rdata_r[`FCC_ST_OVF]    <= rx_r.ovf;
          rdata_r[`FCC_ST_TX_ACT] <= (tx_st_r != FCC_TX_ONES);
          rdata_r[`FCC_ST_LVL_LSB +: PW+1] <= lvl_r;
        end
        `FCC_OFS_RX_FIFO: begin
          // Empty FIFO reads as code zero, never stale memory
          rdata_r[5:0]             <= empty ? `FCC_RST_CODE : mem_r[rd_ptr_r];
          rdata_r[`FCC_FIFO_EMPTY] <= empty;
        end
        default: rdata_r <= `FCC_RST_DATA;
      endcase
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o    = rdata_r;

  // Transmit storage and mode
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_code_first_r  <= `FCC_RST_CODE;
      tx_code_second_r <= `FCC_RST_CODE;
      mode_r           <= FCC_MODE_IDLE;
    end else if (wr_acc) begin
      if (avs_address_i == `FCC_OFS_TX_FIRST) begin
        tx_code_first_r <= avs_writedata_i[5:0];
      end
      if (avs_address_i == `FCC_OFS_TX_SECOND) begin
        tx_code_second_r <= avs_writedata_i[5:0];
      end
      if (avs_address_i == `FCC_OFS_CTRL) begin
        mode_r <= fcc_mode_t'(avs_writedata_i[1:0]);
      end
    end
  end

  // Transmit processor
  assign tx_code = (tx_st_r == FCC_TX_SECOND) ? tx_code_second_r : tx_code_first_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st_r   <= FCC_TX_ONES;
      bit_cnt_r <= 4'h0;
      rep_cnt_r <= 4'h0;
    end else if (wr_acc && avs_address_i == `FCC_OFS_CTRL) begin
      // Mode write restarts the sequence at a codeword boundary
      bit_cnt_r <= 4'h0;
      rep_cnt_r <= 4'h0;
      unique case (fcc_mode_t'(avs_writedata_i[1:0]))
        FCC_MODE_IDLE:   tx_st_r <= FCC_TX_ONES;
        FCC_MODE_SINGLE: tx_st_r <= FCC_TX_FIRST;
        FCC_MODE_DUAL:   tx_st_r <= FCC_TX_FIRST;
        FCC_MODE_CONT:   tx_st_r <= FCC_TX_CONT;
      endcase
    end else if (tx_bit_en_i && tx_st_r != FCC_TX_ONES) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r == 4'(`FCC_CW_LEN - 1) && tx_st_r != FCC_TX_CONT) begin
        rep_cnt_r <= rep_cnt_r + 4'h1;
        if (rep_cnt_r == `FCC_TX_LAST_REP) begin
          rep_cnt_r <= 4'h0;
          if (tx_st_r == FCC_TX_FIRST && mode_r == FCC_MODE_DUAL) begin
            tx_st_r <= FCC_TX_SECOND;
          end else begin
            tx_st_r <= FCC_TX_ONES;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_bit_r <= 1'b1;
    end else if (tx_bit_en_i) begin
      if (tx_st_r == FCC_TX_ONES) begin
        tx_bit_r <= 1'b1;
      end else begin
        tx_bit_r <= cw_bit(tx_code, bit_cnt_r);
      end
    end
  end

  assign tx_bit_o = tx_bit_r;

  // Receive processor
  assign sr_nxt  = {sr_r[14:0], rx_bit_i};
  assign match   = rx_bit_en_i && !sr_nxt[15] && !sr_nxt[8] && (sr_nxt[7:0] == 8'hFF);
  // First arriving code bit lands at bit 0
  assign rx_code = {sr_nxt[9], sr_nxt[10], sr_nxt[11], sr_nxt[12], sr_nxt[13], sr_nxt[14]};
  assign push    = match && since_r == `FCC_RX_CW_GAP && rx_code == last_code_r
                   && run_r == (`FCC_RX_VALID_RUN - 2'h1);
  assign differ  = rx_r.det && rx_bit_en_i &&
                   ((match && rx_code != rx_r.cur_code) ||
                    (!match && since_r == `FCC_RX_CW_GAP));

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sr_r    <= 16'h0000;
      since_r <= 5'h1F;
      ones_r  <= 5'h00;
    end else if (rx_bit_en_i) begin
      sr_r <= sr_nxt;
      if (match) begin
        since_r <= 5'h00;
      end else if (since_r != 5'h1F) begin
        since_r <= since_r + 5'h01;
      end
      if (!rx_bit_i) begin
        ones_r <= 5'h00;
      end else if (ones_r != `FCC_RX_IDLE_ONES) begin
        ones_r <= ones_r + 5'h01;
      end
    end
  end

  // Run of identical codewords spaced one codeword apart
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_code_r <= `FCC_RST_CODE;
      run_r       <= 2'h0;
    end else if (match) begin
      last_code_r <= rx_code;
      if (since_r == `FCC_RX_CW_GAP && rx_code == last_code_r) begin
        if (run_r != `FCC_RX_VALID_RUN) begin
          run_r <= run_r + 2'h1;
        end
      end else begin
        run_r <= 2'h1;
      end
    end else if (rx_bit_en_i && since_r == `FCC_RX_CW_GAP) begin
      run_r <= 2'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      det_r      <= 1'b0;
      cur_code_r <= `FCC_RST_CODE;
      diff_r     <= 1'b0;
    end else if (push) begin
      det_r      <= 1'b1;
      cur_code_r <= rx_code;
      diff_r     <= 1'b0;
    end else if (rx_bit_en_i && rx_bit_i && ones_r == `FCC_RX_IDLE_ONES - 5'h01) begin
      det_r  <= 1'b0;
      diff_r <= 1'b0;
    end else if (differ) begin
      diff_r <= 1'b1;
      if (diff_r) begin
        det_r  <= 1'b0;
        diff_r <= 1'b0;
      end
    end else if (match) begin
      diff_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_r <= 1'b0;
    end else if (push) begin
      idle_r <= 1'b0;
    end else if (rx_bit_en_i && rx_bit_i && ones_r == `FCC_RX_IDLE_ONES - 5'h01) begin
      idle_r <= 1'b1;
    end
  end

  assign rx_r               = '{det: det_r, idle: idle_r, ovf: ovf_r, cur_code: cur_code_r};
  assign rx_code_detected_o = det_r;
  assign rx_idle_o          = idle_r;

  // Receive FIFO
  assign full  = (lvl_r == (PW+1)'(FIFO_DEPTH));
  assign empty = (lvl_r == '0);
  assign pop   = rd_acc && avs_address_i == `FCC_OFS_RX_FIFO && !empty;

  for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_mem
    always_ff @(posedge core_clk_i) begin
      if (push && !full && wr_ptr_r == PW'(i)) begin
        mem_r[i] <= rx_code;
      end
    end
  end

  // Independent pointers keep both sides usable alone
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      lvl_r    <= '0;
    end else begin
      if (push && !full) begin
        wr_ptr_r <= wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      if ((push && !full) && !pop) begin
        lvl_r <= lvl_r + (PW+1)'(1);
      end else if (pop && !(push && !full)) begin
        lvl_r <= lvl_r - (PW+1)'(1);
      end
    end
  end

  // Sticky overflow, write one to clear, set wins
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_r <= 1'b0;
    end else if (push && full) begin
      ovf_r <= 1'b1;
    end else if (wr_acc && avs_address_i == `FCC_OFS_STATUS
                 && avs_writedata_i[`FCC_ST_OVF]) begin
      ovf_r <= 1'b0;
    end
  end

  // Assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_tx_first_bit;
    tx_st_r == FCC_TX_FIRST && tx_bit_en_i && bit_cnt_r == 4'h1 && !wr_acc;
  endsequence

  property p_tx_idle_ones;
    (tx_st_r == FCC_TX_ONES && tx_bit_en_i) |=> tx_bit_o;
  endproperty
  a_tx_idle_ones: assert property (p_tx_idle_ones) else $error("Idle bit not one");

  property p_tx_msb_first;
    s_tx_first_bit |=> tx_bit_o == $past(tx_code_first_r[0]);
  endproperty
  a_tx_msb_first: assert property (p_tx_msb_first) else $error("Code MSB not first");

  property p_tx_frame;
    (tx_st_r != FCC_TX_ONES && tx_bit_en_i && bit_cnt_r == 4'h7) |=> !tx_bit_o;
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("Codeword zero missing");

  property p_tx_single_end;
    (tx_st_r == FCC_TX_FIRST && mode_r == FCC_MODE_SINGLE && tx_bit_en_i && !wr_acc
     && bit_cnt_r == 4'hF && rep_cnt_r == `FCC_TX_LAST_REP) |=> tx_st_r == FCC_TX_ONES;
  endproperty
  a_tx_single_end: assert property (p_tx_single_end) else $error("Single mode overran");

  property p_rx_idle;
    (rx_bit_en_i && rx_bit_i && ones_r == 5'h0F) |=> rx_r.idle && !rx_r.det;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("Idle not declared");

  property p_rx_detect;
    push |=> rx_r.det && !rx_r.idle;
  endproperty
  a_rx_detect: assert property (p_rx_detect) else $error("Detect or idle wrong");

  property p_fifo_ovf;
    (push && full && !pop) |=> rx_r.ovf && lvl_r == $past(lvl_r) && $stable(wr_ptr_r);
  endproperty
  a_fifo_ovf: assert property (p_fifo_ovf) else $error("Overflow mishandled");

  property p_fifo_empty_rd;
    (rd_acc && avs_address_i == `FCC_OFS_RX_FIFO && empty && !push)
      |=> $stable(rd_ptr_r) && lvl_r == '0;
  endproperty
  a_fifo_empty_rd: assert property (p_fifo_empty_rd) else $error("Empty read moved");

  property p_fifo_fill;
    (push && !full && !pop) |=> lvl_r == $past(lvl_r) + (PW+1)'(1);
  endproperty
  a_fifo_fill: assert property (p_fifo_fill) else $error("Level not counted");

  sequence s_bus_wait;
    (avs_read_i || avs_write_i) && wait_r;
  endsequence

  property p_bus_ack;
    s_bus_wait |=> !wait_r ##1 wait_r;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("Waitrequest timing wrong");

endmodule : fcc_feac_ctrl

/* File: fcc_params.svh */
// Register map, field positions, reset values and counts of the FEAC controller
`ifndef FCC_PARAMS_SVH
`define FCC_PARAMS_SVH

`define FCC_ADDR_W        5
`define FCC_OFS_CTRL      5'h00
`define FCC_OFS_TX_FIRST  5'h04
`define FCC_OFS_TX_SECOND 5'h08
`define FCC_OFS_STATUS    5'h0C
`define FCC_OFS_RX_FIFO   5'h10

`define FCC_CODE_W        6
`define FCC_CW_LEN        16
`define FCC_TX_LAST_REP   4'h9
`define FCC_RX_VALID_RUN  2'h3
`define FCC_RX_IDLE_ONES  5'h10
`define FCC_RX_CW_GAP     5'h0F

`define FCC_ST_DET        0
`define FCC_ST_IDLE       1
`define FCC_ST_EMPTY      2
`define FCC_ST_OVF        3
`define FCC_ST_TX_ACT     4
`define FCC_ST_LVL_LSB    5
`define FCC_FIFO_EMPTY    8

`define FCC_RST_CODE      6'h00
`define FCC_RST_DATA      32'h0000_0000

`endif

/* File: fcc_pkg.sv */
// Types shared by the FEAC controller
package fcc_pkg;

  typedef enum logic [1:0] {
    FCC_MODE_IDLE   = 2'b00,
    FCC_MODE_SINGLE = 2'b01,
    FCC_MODE_DUAL   = 2'b10,
    FCC_MODE_CONT   = 2'b11
  } fcc_mode_t;

  typedef enum logic [1:0] {
    FCC_TX_ONES   = 2'b00,
    FCC_TX_FIRST  = 2'b01,
    FCC_TX_SECOND = 2'b10,
    FCC_TX_CONT   = 2'b11
  } fcc_tx_state_t;

  typedef struct packed {
    logic       det;
    logic       idle;
    logic       ovf;
    logic [5:0] cur_code;
  } fcc_rx_status_t;

endpackage : fcc_pkg

/* File: fcc_line_model.sv */
// Framer-side model: bit strobes, receive codeword source
module fcc_line_model (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        run_i,
  input  wire logic [3:0]  gap_i,
  input  wire logic [15:0] rx_word_i,
  output logic             tx_bit_en_o,
  output logic             rx_bit_en_o,
  output logic             rx_bit_o,
  output int               wraps_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0]  cnt_r;
  logic [3:0]  idx_r;
  logic [15:0] cur_r;

  assign rx_bit_en_o = tx_bit_en_o;
  // Line data not valid between strobes
  assign rx_bit_o = rx_bit_en_o ? cur_r[idx_r] : ~cur_r[idx_r];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r       <= 4'h0;
      tx_bit_en_o <= 1'b0;
    end else begin
      cnt_r       <= (cnt_r >= gap_i) ? 4'h0 : cnt_r + 4'h1;
      tx_bit_en_o <= run_i && (cnt_r >= gap_i);
    end
  end

  // New word taken only at a codeword boundary
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx_r   <= 4'hF;
      cur_r   <= 16'hFFFF;
      wraps_o <= 0;
    end else if (rx_bit_en_o) begin
      if (idx_r == 4'h0) begin
        idx_r   <= 4'hF;
        cur_r   <= rx_word_i;
        wraps_o <= wraps_o + 1;
      end else begin
        idx_r <= idx_r - 4'h1;
      end
    end
  end
endmodule : fcc_line_model

/* File: tb_feac_codeword_controller.sv */
// Self-checking testbench of the FEAC codeword controller
`include "fcc_params.svh"
module tb_feac_codeword_controller
  import fcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        arst_n;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic        tx_en;
  logic        tx_bit;
  logic        rx_en;
  logic        rx_bit;
  logic        det;
  logic        idle;
  logic        run;
  logic [3:0]  gap;
  logic [15:0] rx_word;
  int          wraps;
  logic        wr_s;
  logic        en_s;
  logic [31:0] rd_s;
  int          n_fail;
  int          comparisons;
  logic [5:0]  rc [5];

  fcc_feac_ctrl u_dut (
    .core_clk_i        (clk),
    .arst_n_i          (arst_n),
    .avs_address_i     (addr),
    .avs_read_i        (rd),
    .avs_write_i       (wr),
    .avs_writedata_i   (wdata),
    .avs_byteenable_i  (be),
    .avs_readdata_o    (rdata),
    .avs_waitrequest_o (waitreq),
    .tx_bit_en_i       (tx_en),
    .tx_bit_o          (tx_bit),
    .rx_bit_en_i       (rx_en),
    .rx_bit_i          (rx_bit),
    .rx_code_detected_o(det),
    .rx_idle_o         (idle)
  );

  fcc_line_model u_line (
    .core_clk_i (clk),
    .arst_n_i   (arst_n),
    .run_i      (run),
    .gap_i      (gap),
    .rx_word_i  (rx_word),
    .tx_bit_en_o(tx_en),
    .rx_bit_en_o(rx_en),
    .rx_bit_o   (rx_bit),
    .wraps_o    (wraps)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Values held into the next rising edge
  always @(negedge clk) begin
    wr_s = waitreq;
    rd_s = rdata;
    en_s = tx_en;
  end

  function automatic logic [15:0] cw(input logic [5:0] c);
    return {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0, 8'hFF};
  endfunction : cw

  task automatic final_report();
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic hang();
    n_fail++;
    $display("[FAIL] %0t wait limit reached", $time);
    final_report();
  endtask : hang

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge clk);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (wr_s === 1'b0) break;
    end
    if (i == 50) hang();
    q = rd_s;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask : rchk

  task automatic get_tx(output logic b);
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (en_s === 1'b1) break;
    end
    if (i == 100) hang();
    @(negedge clk);
    b = tx_bit;
  endtask : get_tx

  task automatic tx_mode(input logic [1:0] m, input int na, input int nb, input int ones);
    logic        b;
    logic [15:0] w;
    run <= 1'b0;
    @(posedge clk);
    wreg(`FCC_OFS_CTRL, {30'h0, m});
    run <= 1'b1;
    for (int i = 0; i < na + nb; i++) begin
      w = cw(i < na ? 6'h0B : 6'h32);
      for (int j = 15; j >= 0; j--) begin
        get_tx(b);
        check(b, w[j]);
      end
    end
    for (int i = 0; i < ones; i++) begin
      get_tx(b);
      check(b, 1'b1);
    end
  endtask : tx_mode

  task automatic rx_send(input logic [15:0] w, input int n);
    int s;
    int k;
    rx_word <= w;
    s = wraps;
    for (k = 0; k < 5000 && wraps < s + n; k++)
      @(posedge clk);
    if (k == 5000) hang();
    @(negedge clk);
  endtask : rx_send

  task automatic sc_regs();
    check(tx_bit, 1'b1);
    rchk(`FCC_OFS_STATUS, 32'h0000_0004);
    rchk(`FCC_OFS_RX_FIFO, 32'h0000_0100);
    rchk(`FCC_OFS_STATUS, 32'h0000_0004);
    wreg(`FCC_OFS_TX_FIRST, 32'h0000_000B);
    wreg(`FCC_OFS_TX_SECOND, 32'h0000_0032);
    be <= 4'h0;
    wreg(`FCC_OFS_TX_FIRST, 32'h0000_003F);
    be <= 4'hF;
    rchk(`FCC_OFS_TX_FIRST, 32'h0000_000B);
    rchk(`FCC_OFS_TX_SECOND, 32'h0000_0032);
    wreg(5'h14, 32'h0000_0003);
    rchk(5'h14, 32'h0000_0000);
    rchk(`FCC_OFS_CTRL, 32'h0000_0000);
  endtask : sc_regs

  task automatic sc_tx();
    tx_mode(FCC_MODE_SINGLE, 10, 0, 32);
    tx_mode(FCC_MODE_DUAL, 10, 10, 32);
    tx_mode(FCC_MODE_CONT, 12, 0, 0);
    rchk(`FCC_OFS_STATUS, 32'h0000_0016);
    tx_mode(FCC_MODE_IDLE, 0, 0, 32);
  endtask : sc_tx

  task automatic sc_rx();
    logic [2:0] lvl;
    gap <= 4'h2;
    rx_send(16'hFFFF, 2);
    check(idle, 1'b1);
    for (int i = 0; i < 5; i++) begin
      rx_send(cw(rc[i]), 3);
      check(det, 1'b0);
      rx_send(cw(rc[i]), 1);
      check(det, 1'b1);
      check(idle, 1'b0);
      lvl = (i < 4) ? 3'(i + 1) : 3'h4;
      rchk(`FCC_OFS_STATUS, {24'h0, lvl, 1'b0, i == 4, 3'b001});
    end
    for (int i = 0; i < 4; i++)
      rchk(`FCC_OFS_RX_FIFO, {26'h0, rc[i]});
    rchk(`FCC_OFS_RX_FIFO, 32'h0000_0100);
    rchk(`FCC_OFS_STATUS, 32'h0000_000D);
    wreg(`FCC_OFS_STATUS, 32'h0000_0008);
    rchk(`FCC_OFS_STATUS, 32'h0000_0005);
    rx_send(16'hFFFF, 2);
    check(det, 1'b0);
    check(idle, 1'b1);
  endtask : sc_rx

  initial begin
    rc = '{6'h05, 6'h2A, 6'h11, 6'h3C, 6'h27};
    n_fail = 0;
    comparisons = 0;
    arst_n = 1'b0;
    addr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0000_0000;
    be = 4'hF;
    run = 1'b0;
    gap = 4'h0;
    rx_word = 16'hFFFF;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    sc_regs();
    sc_tx();
    sc_rx();
    final_report();
  end
endmodule : tb_feac_codeword_controller
